// ### dcw_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host reading the status byte
module dcw_host_model #(
  parameter int OFFSET_W = 5 // Offset width
) (
  input  wire logic                clock,             // System clock
  input  wire logic [OFFSET_W-1:0] status_afc_offset, // Offset seen
  input  wire logic                status_afc_frozen, // Frozen flag seen
  output logic                     afc_enable,        // Correction flag
  output logic                     status_read        // Read strobe
);
  // Correction runs by default
  initial begin
    afc_enable  = 1'h1;
    status_read = 1'h0;
  end
  // One read; answer taken an edge late since it stands
  task automatic read_status(input logic clr, output logic [OFFSET_W-1:0] ofs,
                             output logic frz);
    @(posedge clock);
    #1;
    afc_enable = !clr;
    @(posedge clock);
    #1;
    status_read = 1'h1;
    @(posedge clock);
    #1;
    status_read = 1'h0;
    @(posedge clock);
    #1;
    ofs = status_afc_offset;
    frz = status_afc_frozen;
    afc_enable = 1'h1;
  endtask
endmodule

// ### dcw_params.svh
`ifndef DCW_PARAMS_SVH
`define DCW_PARAMS_SVH

// ==========================================================
// Clock rate
`define DCW_CLK_PERIOD_NS     10

// ==========================================================
// Sequencer times, in their own units
`define DCW_WAKE_PERIOD_US    300000
`define DCW_OSC_SETTLE_US     2250
`define DCW_MONITOR_US        6000
`define DCW_HOLD_US           30500

// ==========================================================
// Derived cycle counts at the clock rate
`define DCW_WAKE_PERIOD_CYC   ((`DCW_WAKE_PERIOD_US * 1000) / `DCW_CLK_PERIOD_NS)
`define DCW_OSC_SETTLE_CYC    ((`DCW_OSC_SETTLE_US * 1000) / `DCW_CLK_PERIOD_NS)
`define DCW_MONITOR_CYC       ((`DCW_MONITOR_US * 1000) / `DCW_CLK_PERIOD_NS)
`define DCW_HOLD_CYC          ((`DCW_HOLD_US * 1000) / `DCW_CLK_PERIOD_NS)

// ==========================================================
// Signal strength thresholds, signed dBm in 8 bits
`define DCW_RSSI_THR_LOW      8'h99
`define DCW_RSSI_THR_HIGH     8'h9F

// ==========================================================
// Widths and timer step and zero constants
`define DCW_TIMER_W           32
`define DCW_OFFSET_W          5
`define DCW_TIMER_ONE         32'h00000001
`define DCW_TIMER_ZERO        32'h00000000

`endif

// ### dcw_pkg.sv
package dcw_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    DCW_ACTIVE,
    DCW_SLEEP,
    DCW_OSC_WAIT,
    DCW_MONITOR,
    DCW_HOLD,
    DCW_DRAIN
  } dcw_state_t;

endpackage

// ### dcw_seq_sva.sv
`timescale 1ns/10ps
// ==========================================
// Checker on the sequencer ports
module dcw_seq_sva #(
  parameter int unsigned WAKE_PERIOD_CYCLES = 200, // Wake period
  parameter int unsigned OSC_SETTLE_CYCLES  = 10,  // Oscillator settle
  parameter int unsigned MONITOR_CYCLES     = 20,  // Watch window
  parameter int          OFFSET_W           = 5    // Offset width
) (
  input wire logic                clock,               // System clock
  input wire logic                reset_n,             // Reset, active low
  input wire logic                low_power_duty_mode, // Mode pin
  input wire logic                pattern_busy,        // Decoding level
  input wire logic [OFFSET_W-1:0] afc_offset_meas,     // Measured offset
  input wire logic                afc_enable,          // Correction flag
  input wire logic                status_read,         // Read strobe
  input wire logic                osc_enable,          // Oscillator on
  input wire logic                synth_enable,        // Synthesizer on
  input wire logic [OFFSET_W-1:0] status_afc_offset,   // Reported offset
  input wire logic                status_afc_frozen    // Frozen flag
);
  // ==========================================
  // Helper counters, long spans kept out of repetitions
  logic [31:0] settle_cnt;      // Osc on, synth off
  logic [31:0] on_cnt;          // Synth on
  logic [31:0] off_cnt;         // Osc off
  logic [31:0] next_settle_cnt; // Next settle count
  logic [31:0] next_on_cnt;     // Next on count
  logic [31:0] next_off_cnt;    // Next off count
  // Next counts
  always_comb begin
    next_settle_cnt = (osc_enable && !synth_enable) ? settle_cnt + 32'h1 : 32'h0;
    next_on_cnt     = synth_enable ? on_cnt + 32'h1 : 32'h0;
    next_off_cnt    = osc_enable ? 32'h0 : off_cnt + 32'h1;
  end
  // Register counts
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= 32'h0;
      on_cnt     <= 32'h0;
      off_cnt    <= 32'h0;
    end else begin
      settle_cnt <= next_settle_cnt;
      on_cnt     <= next_on_cnt;
      off_cnt    <= next_off_cnt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Assertions
  AST_STATUS_OFFSET: assert property (status_read |=>
    status_afc_offset == $past(afc_offset_meas)) else $error("offset not captured");
  AST_STATUS_FROZEN: assert property (status_read |=>
    status_afc_frozen == !$past(afc_enable)) else $error("frozen flag wrong");
  AST_STATUS_STANDS: assert property (!status_read |=>
    $stable(status_afc_offset) && $stable(status_afc_frozen)) else $error("status moved");
  AST_SYNTH_NEEDS_OSC: assert property (synth_enable |-> osc_enable)
    else $error("synth without osc");
  AST_SETTLE_MAX: assert property (settle_cnt <= OSC_SETTLE_CYCLES)
    else $error("settle too long");
  AST_SETTLE_EXACT: assert property ($rose(synth_enable) && $past(osc_enable) &&
    low_power_duty_mode && $past(low_power_duty_mode, 8) |-> settle_cnt == OSC_SETTLE_CYCLES)
    else $error("settle length wrong");
  AST_CONT_ON: assert property ((!low_power_duty_mode)[*8] |=>
    osc_enable && synth_enable) else $error("not on in continuous mode");
  AST_WAKE_BOUND: assert property (off_cnt <= WAKE_PERIOD_CYCLES + 8)
    else $error("no wake in period");
  AST_MIN_ON: assert property ($fell(synth_enable) |-> on_cnt >= MONITOR_CYCLES)
    else $error("window cut short");
  AST_DOWN_TOGETHER: assert property ($fell(synth_enable) && low_power_duty_mode
    |-> !osc_enable) else $error("osc left on");
  AST_BUSY_KEEP: assert property (low_power_duty_mode[*8] ##0
    (pattern_busy && synth_enable) |=> synth_enable) else $error("off while decoding");
  // Main scenarios reached
  COV_WAKE: cover property ($rose(osc_enable));
  COV_READ: cover property (status_read && !afc_enable);
  COV_BUSY: cover property (pattern_busy && synth_enable);
endmodule

// ### dcw_sequencer.sv
`timescale 1ns/10ps
`include "dcw_params.svh"

module dcw_sequencer #(
  parameter int unsigned WAKE_PERIOD_CYCLES = `DCW_WAKE_PERIOD_CYC, // Wake period
  parameter int unsigned OSC_SETTLE_CYCLES  = `DCW_OSC_SETTLE_CYC,  // Oscillator settle
  parameter int unsigned MONITOR_CYCLES     = `DCW_MONITOR_CYC,     // Signal watch window
  parameter int unsigned HOLD_CYCLES        = `DCW_HOLD_CYC,        // Extended on-time
  parameter int          OFFSET_W           = `DCW_OFFSET_W         // Offset field width
) (
  input  wire logic                clock,               // 100 MHz clock
  input  wire logic                reset_n,             // Async reset, active low
  input  wire logic                low_power_duty_mode, // Mode pin, asynchronous
  input  wire logic                channel_select_bit0, // Threshold pin, asynchronous
  input  wire logic [7:0]          rssi_dbm,            // Signed signal strength, dBm
  input  wire logic                sync_detect,         // Sync word found, pulse
  input  wire logic                pattern_busy,        // Pattern logic decoding, level
  input  wire logic [OFFSET_W-1:0] afc_offset_meas,     // Measured carrier offset
  input  wire logic                afc_enable,          // Correction enable flag
  input  wire logic                status_read,         // Host status read, pulse
  output logic                     osc_enable,          // Crystal oscillator on
  output logic                     synth_enable,        // Synthesizer on
  output logic [OFFSET_W-1:0]      status_afc_offset,   // Offset field of status
  output logic                     status_afc_frozen    // Correction was off at read
);

  // ==========================================================
  // Reset release
  logic [1:0] rst_pipe;  // Release shift
  logic       rst_n;     // Synchronised reset

  // Release only on a clock edge so all flops leave reset together
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ==========================================================
  // Pin synchronisers
  logic [2:0] mode_sync;      // Mode pin stages
  logic [2:0] chan_sync;      // Channel pin stages
  logic       duty_mode;      // Filtered mode
  logic       chan_bit;       // Filtered channel bit
  logic       next_duty_mode; // Next filtered mode
  logic       next_chan_bit;  // Next filtered channel bit

  // Accept a level only when stages two and three agree
  always_comb begin
    next_duty_mode = duty_mode;
    next_chan_bit  = chan_bit;
    if (mode_sync[1] == mode_sync[2]) begin
      next_duty_mode = mode_sync[2];
    end
    if (chan_sync[1] == chan_sync[2]) begin
      next_chan_bit = chan_sync[2];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_sync <= 3'h0;
      chan_sync <= 3'h0;
      duty_mode <= 1'h0;
      chan_bit  <= 1'h0;
    end else begin
      mode_sync <= {mode_sync[1:0], low_power_duty_mode};
      chan_sync <= {chan_sync[1:0], channel_select_bit0};
      duty_mode <= next_duty_mode;
      chan_bit  <= next_chan_bit;
    end
  end

  // ==========================================================
  // Signal strength compare
  logic [7:0] rssi_thr;    // Active threshold
  logic       rssi_above;  // Signal over threshold

  assign rssi_thr   = chan_bit ? `DCW_RSSI_THR_HIGH : `DCW_RSSI_THR_LOW;
  assign rssi_above = ($signed(rssi_dbm) > $signed(rssi_thr));

  // ==========================================================
  // Timers
  logic                    duty_prev;     // Mode one cycle ago
  logic                    wake;          // Wake event
  logic                    period_done;   // Period timer ran out
  logic                    period_load;   // Restart period
  logic                    phase_done;    // Phase timer ran out
  logic                    phase_load;    // Restart phase
  logic [`DCW_TIMER_W-1:0] phase_value;   // Phase length

  // Periodic wake only in duty mode
  assign wake        = duty_mode && duty_prev && period_done;
  assign period_load = wake || (duty_mode && !duty_prev);

  dcw_timer #(
    .WIDTH (`DCW_TIMER_W)
  ) u_period (
    .clock   (clock),
    .rst_n   (rst_n),
    .load    (period_load),
    .value   (`DCW_TIMER_W'(WAKE_PERIOD_CYCLES - 1)),
    .expired (period_done)
  );

  dcw_timer #(
    .WIDTH (`DCW_TIMER_W)
  ) u_phase (
    .clock   (clock),
    .rst_n   (rst_n),
    .load    (phase_load),
    .value   (phase_value),
    .expired (phase_done)
  );

  // ==========================================================
  // Sequencer
  dcw_pkg::dcw_state_t state;       // Current state
  dcw_pkg::dcw_state_t next_state;  // Next state
  logic                next_osc;    // Next oscillator enable
  logic                next_synth;  // Next synthesizer enable

  // Next state and enables; timer loads are one-cycle strobes
  always_comb begin
    next_state  = state;
    next_osc    = osc_enable;
    next_synth  = synth_enable;
    phase_load  = 1'h0;
    phase_value = `DCW_TIMER_W'(OSC_SETTLE_CYCLES);
    if (!duty_mode) begin
      next_state = dcw_pkg::DCW_ACTIVE;
      next_osc   = 1'h1;
      next_synth = 1'h1;
    end else begin
      case (state)
        dcw_pkg::DCW_ACTIVE: begin
          // Mode just went high: power down until first wake
          next_state = dcw_pkg::DCW_SLEEP;
          next_osc   = 1'h0;
          next_synth = 1'h0;
        end
        dcw_pkg::DCW_SLEEP: begin
          if (wake) begin
            next_state  = dcw_pkg::DCW_OSC_WAIT;
            next_osc    = 1'h1;
            phase_load  = 1'h1;
            phase_value = `DCW_TIMER_W'(OSC_SETTLE_CYCLES - 1);
          end
        end
        dcw_pkg::DCW_OSC_WAIT: begin
          if (phase_done) begin
            next_state  = dcw_pkg::DCW_MONITOR;
            next_synth  = 1'h1;
            phase_load  = 1'h1;
            phase_value = `DCW_TIMER_W'(MONITOR_CYCLES - 1);
          end
        end
        dcw_pkg::DCW_MONITOR: begin
          if (rssi_above || sync_detect) begin
            next_state  = dcw_pkg::DCW_HOLD;
            phase_load  = 1'h1;
            phase_value = `DCW_TIMER_W'(HOLD_CYCLES - 1);
          end else if (phase_done) begin
            next_state = dcw_pkg::DCW_DRAIN;
          end
        end
        dcw_pkg::DCW_HOLD: begin
          if (sync_detect) begin
            phase_load  = 1'h1;
            phase_value = `DCW_TIMER_W'(HOLD_CYCLES - 1);
          end else if (phase_done) begin
            next_state = dcw_pkg::DCW_DRAIN;
          end
        end
        dcw_pkg::DCW_DRAIN: begin
          if (sync_detect) begin
            next_state  = dcw_pkg::DCW_HOLD;
            phase_load  = 1'h1;
            phase_value = `DCW_TIMER_W'(HOLD_CYCLES - 1);
          end else if (!pattern_busy) begin
            next_state = dcw_pkg::DCW_SLEEP;
            next_osc   = 1'h0;
            next_synth = 1'h0;
          end
        end
        default: begin
          next_state = dcw_pkg::DCW_SLEEP;
          next_osc   = 1'h0;
          next_synth = 1'h0;
        end
      endcase
    end
  end

  // Registers; reset loads DCW_SLEEP with both enables off, continuous follows a cycle later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state        <= dcw_pkg::DCW_SLEEP;
      osc_enable   <= 1'h0;
      synth_enable <= 1'h0;
      duty_prev    <= 1'h0;
    end else begin
      state        <= next_state;
      osc_enable   <= next_osc;
      synth_enable <= next_synth;
      duty_prev    <= duty_mode;
    end
  end

  // ==========================================================
  // Status offset field
  logic [OFFSET_W-1:0] next_offset;  // Next reported offset
  logic                next_frozen;  // Next frozen flag

  // Offset captured at each status read, held for the host
  always_comb begin
    next_offset = status_afc_offset;
    next_frozen = status_afc_frozen;
    if (status_read) begin
      next_offset = afc_offset_meas;
      next_frozen = !afc_enable;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_afc_offset <= '0;
      status_afc_frozen <= 1'h0;
    end else begin
      status_afc_offset <= next_offset;
      status_afc_frozen <= next_frozen;
    end
  end

endmodule

// ### dcw_timer.sv
`timescale 1ns/10ps
`include "dcw_params.svh"

// Down counter: load a count, reports zero when it has run out
module dcw_timer #(
  parameter int WIDTH = `DCW_TIMER_W
) (
  input  wire logic             clock,   // System clock
  input  wire logic             rst_n,   // Synchronised reset, active low
  input  wire logic             load,    // Load pulse
  input  wire logic [WIDTH-1:0] value,   // Cycles to run
  output logic                  expired  // Count has reached zero
);

  logic [WIDTH-1:0] count;       // Remaining cycles
  logic [WIDTH-1:0] next_count;  // Next remaining cycles

  // ==========================================================
  // Next count
  always_comb begin
    if (load) begin
      next_count = value;
    end else if (count != WIDTH'(`DCW_TIMER_ZERO)) begin
      next_count = count - WIDTH'(`DCW_TIMER_ONE);
    end else begin
      next_count = count;
    end
  end

  // Register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expired = (count == WIDTH'(`DCW_TIMER_ZERO));

endmodule

// ### tb.sv
`timescale 1ns/10ps
module tb;
  // Short counts keep the run small
  localparam int WAKE = 200;
  localparam int OSC  = 10;
  localparam int MON  = 20;
  localparam int HOLD = 40;
  logic       clock, reset_n, low_power_duty_mode, channel_select_bit0;
  logic       sync_detect, pattern_busy, afc_enable, status_read;
  logic       osc_enable, synth_enable, status_afc_frozen, frz;
  logic [7:0] rssi_dbm;
  logic [4:0] afc_offset_meas, status_afc_offset, ofs;
  int         miscompares = 0;
  int         total_checks = 0;
  int         cyc = 0;
  int         last_rise = 0;
  int         on;
  // ==========================================
  // Clock, cycle count, instances
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  dcw_sequencer #(.WAKE_PERIOD_CYCLES(WAKE), .OSC_SETTLE_CYCLES(OSC), .MONITOR_CYCLES(MON),
    .HOLD_CYCLES(HOLD), .OFFSET_W(5)) dut (.clock(clock), .reset_n(reset_n),
    .low_power_duty_mode(low_power_duty_mode), .channel_select_bit0(channel_select_bit0),
    .rssi_dbm(rssi_dbm), .sync_detect(sync_detect), .pattern_busy(pattern_busy),
    .afc_offset_meas(afc_offset_meas), .afc_enable(afc_enable), .status_read(status_read),
    .osc_enable(osc_enable), .synth_enable(synth_enable),
    .status_afc_offset(status_afc_offset), .status_afc_frozen(status_afc_frozen));
  dcw_host_model #(.OFFSET_W(5)) u_host (.clock(clock), .status_afc_offset(status_afc_offset),
    .status_afc_frozen(status_afc_frozen), .afc_enable(afc_enable), .status_read(status_read));
  // ==========================================
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Range compare, unknown never passes
  task automatic chk(input string what, input int lo, input int hi, input logic [31:0] got);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // Bounded wait for an enable level
  task automatic wait_lvl(input bit syn, input logic lvl, output int t);
    int n;
    n = 0;
    while (((syn ? synth_enable : osc_enable) !== lvl) && n < 1000) begin
      tick(1);
      n++;
    end
    chk("enable wait", 0, 999, n);
    t = cyc;
  endtask
  // One wake: returns synth on-time
  task automatic wake(input logic c0, input logic [7:0] lvl, input int sync_at,
                      input int busy_len, output int t_on);
    int t0, t1, t2;
    channel_select_bit0 = c0;
    rssi_dbm = lvl;
    wait_lvl(1'b0, 1'b0, t0);
    wait_lvl(1'b0, 1'b1, t0);
    if (last_rise != 0) chk("wake period", WAKE, WAKE, t0 - last_rise);
    last_rise = t0;
    wait_lvl(1'b1, 1'b1, t1);
    chk("osc settle", OSC, OSC, t1 - t0);
    if (sync_at > 0) begin
      tick(sync_at);
      sync_detect = 1'h1;
      tick(1);
      sync_detect = 1'h0;
    end
    if (busy_len > 0) begin
      pattern_busy = 1'h1;
      tick(busy_len);
      pattern_busy = 1'h0;
    end
    wait_lvl(1'b1, 1'b0, t2);
    chk("osc down", 0, 0, osc_enable);
    t_on = t2 - t1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_status;
    afc_offset_meas = 5'h15;
    u_host.read_status(1'h1, ofs, frz);
    chk("offset", 5'h15, 5'h15, ofs);
    chk("frozen", 1, 1, frz);
    afc_offset_meas = 5'h0A;
    u_host.read_status(1'h0, ofs, frz);
    chk("frozen off", 0, 0, frz);
    afc_offset_meas = 5'h03;
    tick(3);
    chk("offset stands", 5'h0A, 5'h0A, status_afc_offset);
  endtask
  task automatic t_cont;
    low_power_duty_mode = 1'h0;
    tick(12);
    chk("on", 3, 3, {osc_enable, synth_enable});
    tick(2 * WAKE);
    chk("still on", 3, 3, {osc_enable, synth_enable});
  endtask
  task automatic t_threshold;
    low_power_duty_mode = 1'h1;
    wake(1'h0, 8'h99, 0, 0, on);
    chk("equal low thr", MON + 1, MON + 1, on);
    wake(1'h0, 8'h9A, 0, 0, on);
    chk("above low thr", HOLD, HOLD + 6, on);
    wake(1'h1, 8'h9F, 0, 0, on);
    chk("equal high thr", MON + 1, MON + 1, on);
    wake(1'h1, 8'hA0, 0, 0, on);
    chk("above high thr", HOLD, HOLD + 6, on);
  endtask
  task automatic t_sync;
    wake(1'h0, 8'hA0, 30, 0, on);
    chk("sync extends", 30 + HOLD, 30 + HOLD + 5, on);
  endtask
  task automatic t_busy;
    wake(1'h0, 8'h80, 0, 60, on);
    chk("busy holds", 60, 63, on);
  endtask
  // ==========================================
  // Verdict, the only way out
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    clock = 1'h0;
    reset_n = 1'h0;
    low_power_duty_mode = 1'h0;
    channel_select_bit0 = 1'h0;
    rssi_dbm = 8'h80;
    sync_detect = 1'h0;
    pattern_busy = 1'h0;
    afc_offset_meas = 5'h00;
    tick(16);
    reset_n = 1'h1;
    tick(4);
    t_status;
    t_cont;
    t_threshold;
    t_sync;
    t_busy;
    t_cont;
    end_sim;
  end
  // Watchdog, about triple the expected run
  initial begin
    #60000;
    miscompares++;
    $display("ERROR watchdog expected finish seen hang");
    end_sim;
  end
endmodule
bind dcw_sequencer dcw_seq_sva #(.WAKE_PERIOD_CYCLES(WAKE_PERIOD_CYCLES),
  .OSC_SETTLE_CYCLES(OSC_SETTLE_CYCLES), .MONITOR_CYCLES(MONITOR_CYCLES),
  .OFFSET_W(OFFSET_W)) u_sva (.clock(clock), .reset_n(reset_n),
  .low_power_duty_mode(low_power_duty_mode), .pattern_busy(pattern_busy),
  .afc_offset_meas(afc_offset_meas), .afc_enable(afc_enable), .status_read(status_read),
  .osc_enable(osc_enable), .synth_enable(synth_enable),
  .status_afc_offset(status_afc_offset), .status_afc_frozen(status_afc_frozen));
